// ===== shared/yuv_pkg.sv
package yuv_pkg;

  // fixed-point scale of the colour matrix
  localparam int FRAC_BITS = 10;
  localparam int FRAC_ONE  = 1 << FRAC_BITS;
  localparam int ACC_W     = 22;

  // coefficients as printed, in hundredths
  localparam int Y_R_HUND = 30;
  localparam int Y_G_HUND = 59;
  localparam int Y_B_HUND = 11;
  localparam int U_R_HUND = -17;
  localparam int U_G_HUND = -33;
  localparam int U_B_HUND = 50;
  localparam int V_R_HUND = 50;
  localparam int V_G_HUND = -41;
  localparam int V_B_HUND = -9;

  // signed hundredths to the fixed-point scale, rounded half away from zero
  function automatic int to_fixed(input int hund);
    if (hund < 0) begin
      return -(((-hund) * FRAC_ONE + 50) / 100);
    end
    return (hund * FRAC_ONE + 50) / 100;
  endfunction

  localparam int Y_R_COEF = to_fixed(Y_R_HUND);
  localparam int Y_G_COEF = to_fixed(Y_G_HUND);
  localparam int Y_B_COEF = to_fixed(Y_B_HUND);
  localparam int U_R_COEF = to_fixed(U_R_HUND);
  localparam int U_G_COEF = to_fixed(U_G_HUND);
  localparam int U_B_COEF = to_fixed(U_B_HUND);
  localparam int V_R_COEF = to_fixed(V_R_HUND);
  localparam int V_G_COEF = to_fixed(V_G_HUND);
  localparam int V_B_COEF = to_fixed(V_B_HUND);

  localparam int ROUND_HALF = FRAC_ONE / 2;

  localparam logic [8:0] LUMA_OFFSET   = 9'h000;
  localparam logic [8:0] CHROMA_OFFSET = 9'h080;
  localparam int         CODE_MIN      = 0;
  localparam int         CODE_MAX      = 255;
  localparam int         OUT_W         = 8;

  // default sensor sample width and longest line
  localparam int SAMPLE_W_DEF  = 12;
  localparam int MAX_WIDTH_DEF = 2048;

  typedef enum logic {
    chroma_first_422_format = 1'b0,
    luma_first_422_format   = 1'b1
  } fmt_type;

  typedef enum logic [1:0] {
    colour_red   = 2'b00,
    colour_green = 2'b01,
    colour_blue  = 2'b10
  } bayer_colour_type;

  typedef enum logic {
    pair_even_wait = 1'b0,
    pair_odd_wait  = 1'b1
  } pair_state_type;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } rgb_type;

  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] cb;
    logic [7:0] cr;
  } yuv_type;

  typedef struct packed {
    logic    sof;
    logic    eol;
    logic    odd_pix;
    fmt_type fmt;
  } pixel_tag_type;

  localparam int TAG_W = $bits(pixel_tag_type);

  typedef struct packed {
    logic        valid;
    logic        sof;
    logic        eol;
    logic [31:0] word;
  } packed_out_type;

endpackage

// ===== tb/host_buffer_model.sv
`timescale 1ns/1ps
module host_buffer_model
  import yuv_pkg::*;
(
  input wire logic           core_clk,
  input wire packed_out_type out_stream
);
  logic [33:0] got_q[$];

  // no back-pressure: the buffer takes every word in arrival order
  always @(posedge core_clk) begin
    if (out_stream.valid === 1'b1) begin
      got_q.push_back({out_stream.sof, out_stream.eol, out_stream.word});
    end
  end
endmodule

// ===== tb/test_yuv422_pixel_packer.sv
`timescale 1ns/1ps
module test_yuv422_pixel_packer;
  import yuv_pkg::*;
  localparam int MW = 16;
  logic           core_clk = 1'b0;
  logic           rstn = 1'b0;
  logic           in_valid = 1'b0;
  logic           in_sof = 1'b0;
  logic           in_eol = 1'b0;
  logic [11:0]    in_sample = 12'h000;
  fmt_type        format_sel = chroma_first_422_format;
  packed_out_type out_stream;
  logic [33:0]    exp_q[$];
  int             err_count = 0;
  int             checks_done = 0;
  int             pix[4][MW];

  always #12.5 core_clk = ~core_clk;

  yuv422_pixel_packer #(.SAMPLE_W(12), .MAX_WIDTH(MW)) yuv422_pixel_packer_i (
    .core_clk(core_clk), .rstn(rstn), .in_valid(in_valid), .in_sample(in_sample),
    .in_sof(in_sof), .in_eol(in_eol), .format_sel(format_sel), .out_stream(out_stream));
  host_buffer_model host_buffer_model_i (.core_clk(core_clk), .out_stream(out_stream));

  ////////////////////////////////////////////////////////////////////////////
  // 0 red, 1 green, 2 blue; even rows start blue, odd rows start green
  function automatic int colr(int r, int c);
    return r[0] ? (c[0] ? 0 : 1) : (c[0] ? 1 : 2);
  endfunction

  function automatic int clamp(int v);
    return v < 0 ? 0 : (v > 255 ? 255 : v);
  endfunction

  // 2x2 window average then fixed matrix, packed as {luma, cb, cr}
  function automatic logic [23:0] yuv_of(int r, int c);
    int s[3] = '{0, 0, 0};
    int n[3] = '{0, 0, 0};
    int ch[3];
    int rr;
    int cc;
    for (int k = 0; k < 4; k++) begin
      rr = (k[1] && r > 0) ? r - 1 : r;
      cc = (k[0] && c > 0) ? c - 1 : c;
      s[colr(rr, cc)] += pix[rr][cc];
      n[colr(rr, cc)]++;
    end
    for (int k = 0; k < 3; k++) ch[k] = n[k] > 0 ? (s[k] / n[k]) >> 4 : 0;
    return {8'(clamp((307 * ch[0] + 604 * ch[1] + 113 * ch[2] + 512) >>> 10)),
            8'(clamp(((-174 * ch[0] - 338 * ch[1] + 512 * ch[2] + 512) >>> 10) + 128)),
            8'(clamp(((512 * ch[0] - 420 * ch[1] - 92 * ch[2] + 512) >>> 10) + 128))};
  endfunction

  // mode 0 random, 1 black, 2 white, 3 blue sites only (Cb saturates)
  task automatic send_frame(int rows, int cols, fmt_type f, int mode);
    logic [23:0] a;
    logic [23:0] b;
    for (int r = 0; r < rows; r++) begin
      for (int c = 0; c < cols; c++) begin
        pix[r][c] = mode == 0 ? $urandom % 4096 : (mode == 1 ? 0 :
                    (mode == 2 || colr(r, c) == 2) ? 4095 : 0);
        @(negedge core_clk);
        if ($urandom % 4 == 0) begin
          in_valid = 1'b0;
          @(negedge core_clk);
        end
        in_valid  = 1'b1;
        in_sample = 12'(pix[r][c]);
        in_sof    = r == 0 && c == 0;
        in_eol    = c == cols - 1;
        // a format change away from sof must be ignored
        format_sel = in_sof ? f : fmt_type'($urandom % 2);
      end
      for (int c = 0; c < cols; c += 2) begin
        a = yuv_of(r, c);
        b = c + 1 < cols ? yuv_of(r, c + 1) : a;
        exp_q.push_back({r == 0 && c == 0, c + 2 >= cols,
          f == luma_first_422_format ? {a[7:0], b[23:16], a[15:8], a[23:16]}
                                     : {b[23:16], a[7:0], a[23:16], a[15:8]}});
      end
    end
  endtask

  task automatic check_words();
    logic [33:0] g;
    checks_done++;
    if (host_buffer_model_i.got_q.size() != exp_q.size()) begin
      err_count++;
      $display("MISMATCH t=%0t word count %0d", $time, host_buffer_model_i.got_q.size());
    end
    foreach (exp_q[i]) begin
      g = i < host_buffer_model_i.got_q.size() ? host_buffer_model_i.got_q[i] : 'x;
      checks_done++;
      if (g !== exp_q[i]) begin
        err_count++;
        $display("MISMATCH t=%0t word %0d got %h exp %h", $time, i, g, exp_q[i]);
      end
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hca77_7304));
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    // a frame cut after its first pixel must leave no word behind
    @(negedge core_clk);
    in_valid  = 1'b1;
    in_sample = 12'habc;
    in_sof    = 1'b1;
    in_eol    = 1'b0;
    // frames back to back, odd and even line lengths, both byte orders
    for (int i = 0; i < 12; i++) begin
      send_frame(2 + $urandom % 3, 2 + $urandom % (MW - 1), fmt_type'(i % 2), i / 2 % 4);
    end
    @(negedge core_clk);
    in_valid = 1'b0;
    repeat (8) @(negedge core_clk);
    check_words();
    print_verdict();
  end

  // twelve frames of at most 64 pixels with bubbles need under 2000 cycles
  initial begin
    #(25 * 5000);
    err_count++;
    $display("MISMATCH t=%0t run did not finish", $time);
    print_verdict();
  end
endmodule

// ===== tb/yuv422_pixel_packer_sva.sv
`timescale 1ns/1ps
module packer_checker
  import yuv_pkg::*;
#(
  parameter int SAMPLE_W  = 12,
  parameter int MAX_WIDTH = 2048
) (
  input wire logic                core_clk,
  input wire logic                rstn,
  input wire logic                in_valid,
  input wire logic [SAMPLE_W-1:0] in_sample,
  input wire logic                in_sof,
  input wire logic                in_eol,
  input wire fmt_type             format_sel,
  input wire packed_out_type      out_stream
);
  logic    odd_reg, odd_next, spend_reg, spend_next;
  logic    pix_odd, pair_done, pair_sof, tail;
  fmt_type fmt_reg, fmt_next, cur_fmt;

  // column parity restarts on every sof and after every eol
  always_comb begin
    pix_odd    = in_sof ? 1'b0 : odd_reg;
    pair_done  = rstn && in_valid && (pix_odd || in_eol);
    pair_sof   = pair_done && (in_sof || spend_reg);
    tail       = pair_done && !pix_odd;
    cur_fmt    = in_sof ? format_sel : fmt_reg;
    odd_next   = in_valid ? (!in_eol && !pix_odd) : odd_reg;
    spend_next = pair_done ? 1'b0 : ((in_valid && in_sof) || spend_reg);
    fmt_next   = (in_valid && in_sof) ? format_sel : fmt_reg;
  end

  always_ff @(posedge core_clk) begin
    odd_reg   <= rstn && odd_next;
    spend_reg <= rstn && spend_next;
    fmt_reg   <= rstn ? fmt_next : chroma_first_422_format;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property (@(posedge core_clk)
    !rstn |=> out_stream == '0) else $error("output not cleared by reset");
  a_release_quiet: assert property (@(posedge core_clk)
    $rose(rstn) |-> out_stream == '0) else $error("output busy at reset release");
  // three registers lie between the taken pixel and the word: window, matrix, packer
  a_pair_latency: assert property (@(posedge core_clk) disable iff (!rstn)
    pair_done |-> ##3 out_stream.valid) else $error("pair word late or missing");
  a_no_stray: assert property (@(posedge core_clk) disable iff (!rstn)
    out_stream.valid |-> $past(pair_done, 3)) else $error("word without a pair");
  a_sof_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    out_stream.valid |-> out_stream.sof == $past(pair_sof, 3)) else $error("bad sof flag");
  a_eol_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    out_stream.valid |-> out_stream.eol == $past(in_eol, 3)) else $error("bad eol flag");
  // valid itself drops after its pulse, so only the payload must hold
  a_word_stands: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(rstn) && !out_stream.valid |->
      $stable({out_stream.sof, out_stream.eol, out_stream.word}))
    else $error("word changed without valid");
  a_odd_tail: assert property (@(posedge core_clk) disable iff (!rstn)
    out_stream.valid && $past(tail, 3) |-> ($past(cur_fmt, 3) == luma_first_422_format ?
      out_stream.word[23:16] == out_stream.word[7:0] :
      out_stream.word[31:24] == out_stream.word[15:8])) else $error("bad lone pixel word");
endmodule

bind yuv422_pixel_packer packer_checker #(.SAMPLE_W(SAMPLE_W), .MAX_WIDTH(MAX_WIDTH))
  packer_checker_i (.core_clk(core_clk), .rstn(rstn), .in_valid(in_valid),
  .in_sample(in_sample), .in_sof(in_sof), .in_eol(in_eol), .format_sel(format_sel),
  .out_stream(out_stream));

// ===== verilog/rgb_to_yuv.sv
`timescale 1ns/1ps
module rgb_to_yuv
  import yuv_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rstn,
  input  wire logic          in_valid,
  input  wire rgb_type       in_rgb,
  input  wire pixel_tag_type in_tag,
  output logic               out_valid,
  output yuv_type            out_yuv,
  output pixel_tag_type      out_tag
);

  typedef struct packed {
    logic          valid;
    yuv_type       yuv;
    pixel_tag_type tag;
  } conv_state_type;

  conv_state_type st_reg;
  conv_state_type st_next;

  function automatic logic signed [ACC_W-1:0] weigh(input logic [7:0] v, input int coef);
    logic signed [ACC_W-1:0] vx;
    logic signed [ACC_W-1:0] cx;
    vx = ACC_W'($signed({1'b0, v}));
    cx = ACC_W'(coef);
    return ACC_W'(vx * cx);
  endfunction

  function automatic logic [7:0] scale_sat(input logic signed [ACC_W-1:0] acc,
                                           input logic [8:0] offset);
    logic signed [ACC_W-1:0] q;
    q = ACC_W'(acc + ACC_W'(ROUND_HALF)) >>> FRAC_BITS;
    q = ACC_W'(q + ACC_W'($signed({1'b0, offset})));
    if (q < ACC_W'(CODE_MIN)) begin
      return 8'h00;
    end
    if (q > ACC_W'(CODE_MAX)) begin
      return 8'hFF;
    end
    return q[OUT_W-1:0];
  endfunction

  always_comb begin
    logic signed [ACC_W-1:0] y_acc;
    logic signed [ACC_W-1:0] u_acc;
    logic signed [ACC_W-1:0] v_acc;
    st_next       = st_reg;
    y_acc = ACC_W'(weigh(in_rgb.red, Y_R_COEF) + weigh(in_rgb.green, Y_G_COEF)
                   + weigh(in_rgb.blue, Y_B_COEF));
    u_acc = ACC_W'(weigh(in_rgb.red, U_R_COEF) + weigh(in_rgb.green, U_G_COEF)
                   + weigh(in_rgb.blue, U_B_COEF));
    v_acc = ACC_W'(weigh(in_rgb.red, V_R_COEF) + weigh(in_rgb.green, V_G_COEF)
                   + weigh(in_rgb.blue, V_B_COEF));
    st_next.valid = in_valid;
    st_next.tag   = in_tag;
    if (in_valid) begin
      st_next.yuv.luma = scale_sat(y_acc, LUMA_OFFSET);
      st_next.yuv.cb   = scale_sat(u_acc, CHROMA_OFFSET);
      st_next.yuv.cr   = scale_sat(v_acc, CHROMA_OFFSET);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_valid = st_reg.valid;
  assign out_yuv   = st_reg.yuv;
  assign out_tag   = st_reg.tag;

endmodule

// ===== verilog/yuv422_pixel_packer.sv
// Contract
// - Every Bayer sample is interpolated to red, green and blue before conversion; a colour absent from its 2x2 window, as red on the first row, becomes 0.
// - Luma is 0.30 red plus 0.59 green plus 0.11 blue.
// - Blue-difference chroma is -0.17 red -0.33 green +0.50 blue.
// - Red-difference chroma is 0.50 red -0.41 green -0.09 blue.
// - Both chroma results get 128 added so they leave as unsigned 0 to 255.
// - Chroma-first order sends Cb even, Y even, Cr even, Y odd for each pair.
// - Luma-first order sends Y even, Cb even, Y odd, Cr even for each pair.
// - Luma goes out for every pixel except a lone even pixel cut by a new frame, chroma once per pair from the even pixel.
// - Luma bytes are unsigned, 0x00 is level 0 and 0xFF is level 255.
// - Chroma bytes are offset binary with 0x80 as level 0.
// - Both orders share one conversion and encoding, only byte order differs.
`timescale 1ns/1ps
module yuv422_pixel_packer
  import yuv_pkg::*;
#(
  parameter int SAMPLE_W  = SAMPLE_W_DEF,
  parameter int MAX_WIDTH = MAX_WIDTH_DEF
) (
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic                in_valid,
  input  wire logic [SAMPLE_W-1:0] in_sample,
  input  wire logic                in_sof,
  input  wire logic                in_eol,
  input  wire fmt_type             format_sel,
  output packed_out_type           out_stream
);

  localparam int COL_W = $clog2(MAX_WIDTH);
  localparam int SUM_W = SAMPLE_W + 2;

  typedef struct packed {
    logic [COL_W-1:0]    col;
    logic                row_odd;
    logic                first_row;
    logic [SAMPLE_W-1:0] left_sample;
    logic [SAMPLE_W-1:0] aboveleft_sample;
    fmt_type             frame_fmt;
    logic                s1_valid;
    rgb_type             s1_rgb;
    pixel_tag_type       s1_tag;
    pair_state_type      phase;
    yuv_type             even_pix;
    logic                even_sof;
    packed_out_type      out;
  } pack_state_type;

  pack_state_type st_reg;
  pack_state_type st_next;

  // previous sensor line; one sample per column
  logic [SAMPLE_W-1:0] line_mem [MAX_WIDTH];

  logic          cv_valid;
  yuv_type       cv_yuv;
  pixel_tag_type cv_tag;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic bayer_colour_type bayer_colour(input logic row_odd,
                                                    input logic col_odd);
    if (!row_odd && !col_odd) begin
      return colour_blue;
    end
    if (row_odd && col_odd) begin
      return colour_red;
    end
    return colour_green;
  endfunction

  // average each colour over the 2x2 window; duplicated edge samples count twice, the first-row corner sample four times
  function automatic rgb_type interpolate(input logic [3:0][SAMPLE_W-1:0] smp,
                                          input bayer_colour_type [3:0] col);
    logic [2:0][SUM_W-1:0] sum;
    logic [2:0][2:0]       cnt;
    logic [2:0][SUM_W-1:0] avg;
    rgb_type               res;
    sum = '0;
    cnt = '0;
    avg = '0;
    for (int i = 0; i < 4; i++) begin
      for (int c = 0; c < 3; c++) begin
        if (col[i] == bayer_colour_type'(c)) begin
          sum[c] = SUM_W'(sum[c] + SUM_W'(smp[i]));
          cnt[c] = 3'(cnt[c] + 3'd1);
        end
      end
    end
    for (int c = 0; c < 3; c++) begin
      case (cnt[c])
        3'd4: begin
          avg[c] = sum[c] >> 2;
        end
        3'd2: begin
          avg[c] = sum[c] >> 1;
        end
        3'd1: begin
          avg[c] = sum[c];
        end
        default: begin
          avg[c] = '0;
        end
      endcase
    end
    res.red   = avg[0][SAMPLE_W-1 -: 8];
    res.green = avg[1][SAMPLE_W-1 -: 8];
    res.blue  = avg[2][SAMPLE_W-1 -: 8];
    return res;
  endfunction

  function automatic logic [31:0] pack_word(input fmt_type fmt, input yuv_type ev,
                                            input logic [7:0] odd_luma);
    // byte 0 of the stream sits in bits 7:0
    case (fmt)
      chroma_first_422_format: begin
        return {odd_luma, ev.cr, ev.luma, ev.cb};
      end
      luma_first_422_format: begin
        return {ev.cr, odd_luma, ev.cb, ev.luma};
      end
      default: begin
        return {odd_luma, ev.cr, ev.luma, ev.cb};
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // window, interpolation and packing

  logic [COL_W-1:0] eff_col;
  logic             eff_first;
  logic             eff_row_odd;
  logic             above_row_odd;
  logic             left_col_odd;

  always_comb begin
    logic [3:0][SAMPLE_W-1:0] win;
    bayer_colour_type [3:0]   win_col;
    logic [SAMPLE_W-1:0]      above;
    fmt_type                  pix_fmt;
    st_next         = st_reg;
    st_next.out.valid = 1'b0;
    // a start of frame restarts the position counters on this very pixel
    eff_col       = in_sof ? '0 : st_reg.col;
    eff_first     = in_sof | st_reg.first_row;
    eff_row_odd   = in_sof ? 1'b0 : st_reg.row_odd;
    // borders reuse the current row or column in place of the missing one
    above         = eff_first ? in_sample : line_mem[eff_col];
    above_row_odd = eff_first ? eff_row_odd : ~eff_row_odd;
    left_col_odd  = (eff_col == '0) ? eff_col[0] : ~eff_col[0];
    win[0]        = in_sample;
    win[1]        = (eff_col == '0) ? in_sample : st_reg.left_sample;
    win[2]        = above;
    win[3]        = (eff_col == '0) ? above : st_reg.aboveleft_sample;
    win_col[0]    = bayer_colour(eff_row_odd, eff_col[0]);
    win_col[1]    = bayer_colour(eff_row_odd, left_col_odd);
    win_col[2]    = bayer_colour(above_row_odd, eff_col[0]);
    win_col[3]    = bayer_colour(above_row_odd, left_col_odd);
    // format is sampled only with the first pixel of a frame
    pix_fmt       = in_sof ? format_sel : st_reg.frame_fmt;

    st_next.s1_valid = in_valid;
    if (in_valid) begin
      st_next.s1_rgb           = interpolate(win, win_col);
      st_next.s1_tag           = '{sof: in_sof, eol: in_eol, odd_pix: eff_col[0],
                                   fmt: pix_fmt};
      st_next.frame_fmt        = pix_fmt;
      st_next.left_sample      = in_sample;
      st_next.aboveleft_sample = above;
      if (in_eol) begin
        st_next.col       = '0;
        st_next.row_odd   = ~eff_row_odd;
        st_next.first_row = 1'b0;
      end else begin
        st_next.col       = COL_W'(eff_col + 1'b1);
        st_next.row_odd   = eff_row_odd;
        st_next.first_row = eff_first;
      end
    end

    // chroma taken from the even pixel of each pair
    if (cv_valid) begin
      case (st_reg.phase)
        pair_even_wait: begin
          st_next.even_pix = cv_yuv;
          st_next.even_sof = cv_tag.sof;
          if (cv_tag.eol) begin
            // odd line width: last pixel repeats its own luma
            st_next.out = '{valid: 1'b1, sof: cv_tag.sof, eol: 1'b1,
                            word: pack_word(cv_tag.fmt, cv_yuv, cv_yuv.luma)};
          end else begin
            st_next.phase = pair_odd_wait;
          end
        end
        pair_odd_wait: begin
          if (cv_tag.sof) begin
            // a new frame cuts the pending pair; the lone even pixel is dropped
            st_next.even_pix = cv_yuv;
            st_next.even_sof = 1'b1;
            st_next.phase    = cv_tag.eol ? pair_even_wait : pair_odd_wait;
            if (cv_tag.eol) begin
              st_next.out = '{valid: 1'b1, sof: 1'b1, eol: 1'b1,
                              word: pack_word(cv_tag.fmt, cv_yuv, cv_yuv.luma)};
            end
          end else begin
            // same values, order chosen by the pixel's format
            st_next.out   = '{valid: 1'b1, sof: st_reg.even_sof, eol: cv_tag.eol,
                              word: pack_word(cv_tag.fmt, st_reg.even_pix, cv_yuv.luma)};
            st_next.phase = pair_even_wait;
          end
        end
        default: begin
          st_next.phase = pair_even_wait;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // line store carries no reset; the first row never reads it
  always_ff @(posedge core_clk) begin
    if (in_valid) begin
      line_mem[eff_col] <= in_sample;
    end
  end

  rgb_to_yuv u_conv (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (st_reg.s1_valid),
    .in_rgb    (st_reg.s1_rgb),
    .in_tag    (st_reg.s1_tag),
    .out_valid (cv_valid),
    .out_yuv   (cv_yuv),
    .out_tag   (cv_tag)
  );

  assign out_stream = st_reg.out;

endmodule
